/* byte_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             resetn,
    // fill side
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  in_ready,
    // drain side
    output logic                  out_valid,
    output logic [WIDTH-1:0]      out_data,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wp;
        logic [AW-1:0]               rp;
        logic [AW:0]                 cnt;
    } fifo_state_t;

    fifo_state_t s_q;
    fifo_state_t s_d;
    logic        push;
    logic        pop;

    assign in_ready  = (s_q.cnt != (AW+1)'(DEPTH));
    assign out_valid = (s_q.cnt != '0);
    assign out_data  = s_q.mem[s_q.rp];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always_comb begin
        s_d = s_q;
        if (push) begin
            s_d.mem[s_q.wp] = in_data;
            s_d.wp          = (s_q.wp == AW'(DEPTH - 1)) ? '0 : s_q.wp + 1'b1;
        end
        if (pop) begin
            s_d.rp = (s_q.rp == AW'(DEPTH - 1)) ? '0 : s_q.rp + 1'b1;
        end
        s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule
`default_nettype wire

/* line_master.sv */
`timescale 1ns/1ps
`default_nettype none
module line_master (
    // clock
    input  wire logic          clk,
    // slave receive and transmit sides
    output var msg_pkg::byte_t rx,
    input  wire logic          tx_valid,
    input  wire logic [7:0]    tx_data,
    output logic               tx_ready
);
    import msg_pkg::*;
    logic [7:0] got[$];
    logic [1:0] phase;
    logic       slow;
    logic       bad_crc;
    initial begin
        rx = '0;
        tx_ready = 1'b0;
        phase = '0;
        slow = 1'b0;
        bad_crc = 1'b0;
    end
    function automatic logic [15:0] crc16(input logic [7:0] q[$]);
        logic [15:0] c;
        c = 16'hffff;
        foreach (q[i]) begin
            c = c ^ {8'h00, q[i]};
            for (int b = 0; b < 8; b++) begin
                c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
            end
        end
        return c;
    endfunction
    // slow mode takes one byte in four, so the reply fifo fills up behind it
    always @(negedge clk) begin
        phase <= phase + 2'd1;
        tx_ready <= !slow || (phase == 2'd0);
    end
    always @(posedge clk) begin
        if (tx_valid && tx_ready) begin
            got.push_back(tx_data);
        end
    end
    task automatic xfer(input logic [7:0] m[$], output logic [7:0] r[$]);
        logic [15:0] c;
        int quiet;
        c = crc16(m) ^ {15'h0, bad_crc};
        m.push_back(c[7:0]);
        m.push_back(c[15:8]);
        got.delete();
        foreach (m[i]) begin
            @(negedge clk);
            rx <= {1'b1, m[i]};
            @(negedge clk);
            rx <= {1'b0, ~m[i]};
        end
        quiet = 0;
        while (quiet < 60) begin
            @(negedge clk);
            quiet = tx_valid ? 0 : quiet + 1;
        end
        r = got;
    endtask
endmodule
`default_nettype wire

/* msg_params.svh */
`ifndef MSG_PARAMS_SVH
`define MSG_PARAMS_SVH

`define FN_READ         8'h03
`define FN_LOOP         8'h08
`define FN_WRITE        8'h10
`define FN_ERR_BIT      8'h80
`define ADDR_BCAST      8'h00
`define ADDR_MAX        8'h20
`define MAX_REGS        16'h0010
`define BCAST_REG_RUN   16'h0001
`define BCAST_REG_FREQ  16'h0002
`define CRC_PRESET      16'hffff
`define CRC_POLY_REFL   16'ha001
`define ERR_FUNC        8'h01
`define ERR_ADDR        8'h02
`define ERR_COUNT       8'h03
`define READ_REQ_LEN    5'd8
`define HDR_LEN         5'd6
// longest write byte count the 6-bit frame index can follow to its crc
`define RX_BCNT_LIMIT   8'd54
`define FIFO_DEPTH      4
`define IDLE_GAP_NS     875000
`define CLK_NS          25
`define IDLE_GAP_CYC    ((`IDLE_GAP_NS + `CLK_NS - 1) / `CLK_NS)

`endif

/* msg_pkg.sv */
package msg_pkg;
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } byte_t;

    typedef struct packed {
        logic        req;
        logic        wr;
        logic [15:0] addr;
        logic [15:0] wdata;
    } reg_req_t;

    typedef enum logic [2:0] {
        ST_RX, ST_DISCARD, ST_EXEC, ST_RESP_HDR, ST_RESP_DATA, ST_CRC_LO, ST_CRC_HI
    } state_t;
endpackage

/* msg_slave.sv */
// Functional notes
// RQ1: read request is eight bytes, function 03
// RQ2: read reply echoes, byte count, values, crc
// RQ3: error reply: address, function|80, code, crc
// RQ4: write carries at most sixteen register words
// RQ5: write request layout with byte count field
// RQ6: write reply echoes start and count
// RQ7: broadcast writes only registers 0001, 0002
// RQ8: two-byte fields sent high byte first
// RQ9: address 00 to 20, never answer broadcast
// RQ10: crc16 reflected, preset ones, lsb first
// RQ11: only 03, 08, 10 accepted, else error
// RQ12: master checks crc of each reply
// RQ13: crc sent low byte then high byte
`include "msg_params.svh"
`timescale 1ns/1ps
`default_nettype none
module msg_slave #(
    parameter int          IDLE_CYC = `IDLE_GAP_CYC,
    parameter logic [7:0]  MY_ADDR  = 8'h01
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             resetn,
    // received bytes from the line receiver
    input  wire msg_pkg::byte_t   rx,
    // bytes toward the line transmitter
    output logic                  tx_valid,
    output logic [7:0]            tx_data,
    input  wire logic             tx_ready,
    // register port of the device
    output msg_pkg::reg_req_t     reg_req,
    input  wire logic [15:0]      reg_rdata
);
    import msg_pkg::*;

    typedef struct packed {
        state_t      st;
        logic [5:0]  idx;
        logic [7:0]  addr;
        logic [7:0]  fn;
        logic [15:0] start;
        logic [15:0] count;
        logic [7:0]  bcnt;
        logic [7:0]  err;
        logic [15:0] crc;
        logic [15:0] wptr;
        logic [7:0]  hi;
        logic [21:0] idle;
        logic [15:0] rword;
        logic        rhalf;
        logic        push;
        logic [7:0]  pbyte;
        reg_req_t    rq;
    } core_t;

    core_t      s_q;
    core_t      s_d;
    logic       f_ready;
    logic       f_valid;
    logic [7:0] f_data;
    logic [5:0] need;
    logic [5:0] resp_len;
    logic       f_take;
    logic       bcast_ok;
    logic       wr_ok;

    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c ^ {8'h00, b};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ `CRC_POLY_REFL) : (r >> 1);  // [RQ10]
        end
        return r;
    endfunction

    // total request length once the header fields are known
    always_comb begin
        need = 6'(`READ_REQ_LEN);  // [RQ1]
        if (s_q.fn == `FN_WRITE) begin
            need = 6'(7) + s_q.bcnt[5:0] + 6'd2;  // [RQ5]
        end
    end

    // the fifo pops only when the output register really takes its head,
    // otherwise a stalled line would lose the byte at the fifo head
    assign f_take = !tx_valid || tx_ready;

    // start is bounded first so the end-of-range sum cannot wrap
    assign bcast_ok = (s_q.start >= `BCAST_REG_RUN) && (s_q.start <= `BCAST_REG_FREQ)
                      && (s_q.count <= `BCAST_REG_FREQ + 16'd1 - s_q.start);  // [RQ7]

    // writes leave before the crc is known, so the frame must be legal to write at all
    assign wr_ok = (s_q.count <= `MAX_REGS)
                   && (s_q.addr != `ADDR_BCAST || bcast_ok);  // [RQ4] [RQ7]

    byte_fifo #(.WIDTH(8), .DEPTH(`FIFO_DEPTH)) u_fifo (
        .clk       (clk),
        .resetn    (resetn),
        .in_valid  (s_q.push),
        .in_data   (s_q.pbyte),
        .in_ready  (f_ready),
        .out_valid (f_valid),
        .out_data  (f_data),
        .out_ready (f_take)
    );

    // header length for the reply before its data or crc
    always_comb begin
        resp_len = 6'd6;  // [RQ6]
        if (s_q.err != 8'h00) begin
            resp_len = 6'd3;  // [RQ3]
        end else if (s_q.fn == `FN_READ) begin
            resp_len = 6'd3;  // [RQ2]
        end
    end

    always_comb begin
        s_d          = s_q;
        s_d.push     = 1'b0;
        s_d.rq.req   = 1'b0;
        if (s_q.push && !f_ready) begin
            s_d.push = 1'b1;
        end
        case (s_q.st)
            ST_RX, ST_DISCARD: begin
                if (rx.valid) begin
                    s_d.idle = '0;
                end else if (s_q.idle != 22'(IDLE_CYC)) begin
                    s_d.idle = s_q.idle + 22'd1;
                end
                // a line gap ends any partial frame
                if (!rx.valid && s_q.idle == 22'(IDLE_CYC) - 22'd1) begin
                    s_d.st  = ST_RX;
                    s_d.idx = '0;
                    s_d.crc = `CRC_PRESET;
                end
                if (rx.valid && s_q.st == ST_RX) begin
                    s_d.idx = s_q.idx + 6'd1;
                    if (s_q.idx < need - 6'd2) begin
                        s_d.crc = crc_step(s_q.crc, rx.data);
                    end
                    case (s_q.idx)
                        6'd0: begin
                            s_d.addr = rx.data;
                            s_d.err  = 8'h00;
                            s_d.bcnt = 8'h00;
                            if (rx.data != MY_ADDR && rx.data != `ADDR_BCAST) begin  // [RQ9]
                                s_d.st = ST_DISCARD;
                            end
                        end
                        6'd1: s_d.fn = rx.data;
                        6'd2: s_d.start[15:8] = rx.data;  // [RQ8]
                        6'd3: s_d.start[7:0]  = rx.data;
                        6'd4: s_d.count[15:8] = rx.data;
                        6'd5: s_d.count[7:0]  = rx.data;
                        6'd6: begin
                            if (s_q.fn == `FN_WRITE) begin
                                s_d.bcnt = rx.data;
                                // a count the frame index cannot follow is dropped unanswered;
                                // a shorter over-range count runs on and gets an error reply
                                if (rx.data != s_q.count[6:0] * 7'd2
                                    || rx.data > `RX_BCNT_LIMIT) begin
                                    s_d.st = ST_DISCARD;
                                end
                            end
                        end
                        default: ;
                    endcase
                    if (s_q.fn == `FN_WRITE && s_q.idx >= 6'd7 && s_q.idx < need - 6'd2) begin
                        s_d.hi = rx.data;
                    end else if (s_q.idx == need - 6'd2) begin
                        s_d.hi = rx.data;
                    end
                    if (s_q.idx == need - 6'd1 && s_q.idx >= 6'(`READ_REQ_LEN) - 6'd1) begin
                        // crc arrives low byte first
                        if ({rx.data, s_q.hi} == s_q.crc) begin  // [RQ13]
                            s_d.st   = ST_EXEC;
                            s_d.idx  = '0;
                            s_d.wptr = s_q.start;
                        end else begin
                            s_d.st = ST_DISCARD;
                        end
                    end
                end
            end
            ST_EXEC: begin
                s_d.idx = '0;
                s_d.crc = `CRC_PRESET;
                if (s_q.fn != `FN_READ && s_q.fn != `FN_WRITE && s_q.fn != `FN_LOOP) begin
                    s_d.err = `ERR_FUNC;  // [RQ11]
                end else if (s_q.count == 16'h0000 || s_q.count > `MAX_REGS) begin
                    s_d.err = `ERR_COUNT;  // [RQ4]
                end else if (s_q.addr == `ADDR_BCAST && s_q.fn == `FN_WRITE && !bcast_ok) begin
                    s_d.err = `ERR_ADDR;  // [RQ7]
                end
                s_d.st = ST_RESP_HDR;
                if (s_q.addr == `ADDR_BCAST) begin
                    s_d.st = ST_DISCARD;  // [RQ9]
                end
            end
            default: ;
        endcase
        // reply bytes pass through the fifo; a full fifo stalls the sequencer
        if (!s_d.push) begin
            case (s_q.st)
                ST_RESP_HDR: begin
                    s_d.push = 1'b1;
                    case (s_q.idx)
                        6'd0: s_d.pbyte = s_q.addr;
                        6'd1: s_d.pbyte = (s_q.err != 8'h00) ? (s_q.fn | `FN_ERR_BIT) : s_q.fn;
                        6'd2: s_d.pbyte = (s_q.err != 8'h00) ? s_q.err
                                        : (s_q.fn == `FN_READ) ? s_q.count[6:0] * 8'd2
                                        : s_q.start[15:8];  // [RQ2] [RQ3]
                        6'd3: s_d.pbyte = s_q.start[7:0];
                        6'd4: s_d.pbyte = s_q.count[15:8];  // [RQ8]
                        default: s_d.pbyte = s_q.count[7:0];
                    endcase
                    s_d.crc = crc_step(s_q.crc, s_d.pbyte);  // [RQ10]
                    s_d.idx = s_q.idx + 6'd1;
                    if (s_q.idx == resp_len - 6'd1) begin
                        s_d.idx   = '0;
                        s_d.rhalf = 1'b0;
                        s_d.st    = (s_q.err == 8'h00 && s_q.fn == `FN_READ) ? ST_RESP_DATA
                                                                               : ST_CRC_LO;
                        s_d.rq = '{req: (s_q.err == 8'h00 && s_q.fn == `FN_READ),
                                   wr: 1'b0, addr: s_q.wptr, wdata: 16'h0000};
                    end
                end
                ST_RESP_DATA: begin
                    if (s_q.rhalf) begin
                        s_d.push  = 1'b1;
                        s_d.pbyte = s_q.rhalf && s_q.idx[0] ? s_q.rword[7:0] : s_q.rword[15:8];
                        s_d.crc   = crc_step(s_q.crc, s_d.pbyte);
                        s_d.idx   = s_q.idx + 6'd1;
                        if (s_q.idx[0]) begin
                            s_d.rhalf = 1'b0;
                            s_d.wptr  = s_q.wptr + 16'd1;
                            if (s_q.idx == 6'(s_q.count[5:0] * 6'd2) - 6'd1) begin
                                s_d.st = ST_CRC_LO;
                            end else begin
                                s_d.rq = '{req: 1'b1, wr: 1'b0, addr: s_q.wptr + 16'd1,
                                           wdata: 16'h0000};
                            end
                        end
                    end else if (!s_q.rq.req) begin
                        s_d.rword = reg_rdata;  // value sent high byte first [RQ8]
                        s_d.rhalf = 1'b1;
                    end
                end
                ST_CRC_LO: begin
                    s_d.push  = 1'b1;
                    s_d.pbyte = s_q.crc[7:0];  // [RQ13]
                    s_d.st    = ST_CRC_HI;
                end
                ST_CRC_HI: begin
                    s_d.push  = 1'b1;
                    s_d.pbyte = s_q.crc[15:8];
                    s_d.st    = ST_DISCARD;
                end
                default: ;
            endcase
        end
        // register writes are issued as each word completes, before the crc is known
        if (s_q.st == ST_RX && rx.valid && s_q.fn == `FN_WRITE && s_q.idx >= 6'd8
            && s_q.idx < need - 6'd2 && s_q.idx[0] == 1'b0 && wr_ok) begin
            s_d.rq = '{req: 1'b1, wr: 1'b1,
                       addr: s_q.start + 16'((s_q.idx - 6'd8) >> 1),
                       wdata: {s_q.hi, rx.data}};  // [RQ5] [RQ8]
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_q     <= '0;
            s_q.crc <= `CRC_PRESET;
        end else begin
            s_q <= s_d;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tx_valid <= 1'b0;
            tx_data  <= 8'h00;
            reg_req  <= '0;
        end else begin
            if (f_take) begin
                tx_valid <= f_valid;
                tx_data  <= f_data;
            end
            reg_req <= s_d.rq;
        end
    end
endmodule
`default_nettype wire

/* msg_slave_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module msg_slave_checker #(
    parameter int         IDLE_CYC = 20,
    parameter logic [7:0] MY_ADDR  = 8'h01
) (
    // clock and reset
    input wire logic              clk,
    input wire logic              resetn,
    // line and register sides
    input wire msg_pkg::byte_t    rx,
    input wire logic              tx_valid,
    input wire logic [7:0]        tx_data,
    input wire logic              tx_ready,
    input wire msg_pkg::reg_req_t reg_req
);
    import msg_pkg::*;
    typedef struct packed {
        logic [31:0] gap;
        logic        nxt;
        logic [5:0]  txn;
        logic [7:0]  dst;
        logic [7:0]  fn;
    } mon_t;
    mon_t s_q;
    mon_t s_d;
    logic sof;
    logic bad_fn;
    // a byte after a full quiet gap opens a frame, as the slave sees it
    assign sof = rx.valid && (s_q.gap >= 32'(IDLE_CYC));
    assign bad_fn = !(s_q.fn inside {8'h03, 8'h08, 8'h10});
    always_comb begin
        s_d = s_q;
        s_d.gap = rx.valid ? '0 : s_q.gap + 32'(s_q.gap < 32'(IDLE_CYC));
        s_d.txn = sof ? '0 : s_q.txn + 6'(tx_valid && tx_ready);
        s_d.nxt = rx.valid ? sof : s_q.nxt;
        s_d.dst = sof ? rx.data : s_q.dst;
        s_d.fn = (rx.valid && s_q.nxt) ? rx.data : s_q.fn;
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_q <= '{gap: 32'(IDLE_CYC), default: '0};
        end else begin
            s_q <= s_d;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    a_tx_hold:
        assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("reply byte not held");
    a_own_addr:
        assert property (tx_valid |-> s_q.dst == MY_ADDR) else $error("reply to other address");
    a_bcast_silent:
        assert property (tx_valid |-> s_q.dst != 8'h00) else $error("reply to broadcast");
    a_reply_addr:
        assert property (tx_valid && s_q.txn == 6'd0 |-> tx_data == MY_ADDR)
        else $error("first reply byte wrong");
    a_func_echo:
        assert property (tx_valid && s_q.txn == 6'd1 |-> tx_data[6:0] == s_q.fn[6:0])
        else $error("function not echoed");
    a_bad_func:
        assert property (tx_valid && s_q.txn == 6'd1 && bad_fn |-> tx_data == (s_q.fn | 8'h80))
        else $error("bad function not flagged");
    a_quiet_rx:
        assert property (rx.valid |-> !tx_valid) else $error("reply during request");
    a_wr_func:
        assert property (reg_req.req && reg_req.wr |-> s_q.fn == 8'h10)
        else $error("write outside write function");
    a_bcast_regs:
        assert property (reg_req.req && reg_req.wr && s_q.dst == 8'h00
            |-> reg_req.addr inside {16'h0001, 16'h0002})
        else $error("broadcast wrote other register");
    c_error: cover property (tx_valid && tx_ready && s_q.txn == 6'd1 && tx_data[7]);
    c_stall: cover property (tx_valid && !tx_ready [*3]);
    c_bcast_wr: cover property (reg_req.req && reg_req.wr && s_q.dst == 8'h00);
endmodule
`default_nettype wire

/* tb_serial_register_read_write_slave.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_serial_register_read_write_slave;
    import msg_pkg::*;
    logic        clk;
    logic        resetn;
    byte_t       rx;
    logic        tx_valid;
    logic [7:0]  tx_data;
    logic        tx_ready;
    reg_req_t    reg_req;
    logic [15:0] reg_rdata;
    int          n_errors;
    int          total_checks;
    logic [31:0] wlog[$];
    logic [7:0]  r[$];
    logic [7:0]  e[$];
    msg_slave #(.IDLE_CYC(20), .MY_ADDR(8'h02)) DUT (.clk(clk), .resetn(resetn), .rx(rx),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .reg_req(reg_req),
        .reg_rdata(reg_rdata));
    line_master M (.clk(clk), .rx(rx), .tx_valid(tx_valid), .tx_data(tx_data),
        .tx_ready(tx_ready));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // register stand-in: a read returns the address byte and its complement
    always @(negedge clk) begin
        if (reg_req.req && !reg_req.wr) begin
            reg_rdata <= {reg_req.addr[7:0], ~reg_req.addr[7:0]};
        end
        if (reg_req.req && reg_req.wr) begin
            wlog.push_back({reg_req.addr, reg_req.wdata});
        end
    end
    task automatic check(input logic [31:0] g, input logic [31:0] x);
        total_checks++;
        if (g !== x) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, g, x);
        end
    endtask
    task automatic mk(input logic [255:0] v, input int n);
        e.delete();
        for (int i = n - 1; i >= 0; i--) begin
            e.push_back(v[8*i +: 8]);
        end
    endtask
    task automatic go(input logic [255:0] v, input int n);
        mk(v, n);
        M.xfer(e, r);
    endtask
    task automatic expect_reply(input logic [255:0] v, input int n);
        logic [15:0] c;
        mk(v, n);
        c = M.crc16(e);
        if (n > 0) begin
            e.push_back(c[7:0]);
            e.push_back(c[15:8]);
        end
        check(r.size(), e.size());
        foreach (e[i]) begin
            check(r[i], e[i]);
        end
    endtask
    task automatic t_read();
        mk(48'h0203_0020_0004, 6);
        check(M.crc16(e), 16'hf045);
        mk(88'h020308_0065_0000_0000_01f4, 11);
        check(M.crc16(e), 16'h82af);
        M.slow = 1'b1;
        go(48'h0203_0020_0004, 6);
        M.slow = 1'b0;
        expect_reply(88'h020308_20df_21de_22dd_23dc, 11);
    endtask
    task automatic t_write();
        wlog.delete();
        mk(88'h0110_0001_0002_04_0001_0258, 11);
        check(M.crc16(e), 16'h3963);
        go(88'h0210_0001_0002_04_0001_0258, 11);
        expect_reply(48'h0210_0001_0002, 6);
        check(wlog.size(), 2);
        check(wlog[0], 32'h0001_0001);
        check(wlog[1], 32'h0002_0258);
    endtask
    task automatic t_count();
        int n;
        for (int k = 0; k < 3; k++) begin
            n = (k == 0) ? 16 : (k == 1) ? 17 : 0;
            wlog.delete();
            mk({8'h02, 8'h10, 16'h0040, 16'(n), 8'(2 * n)}, 7);
            for (int w = 0; w < n; w++) begin
                e.push_back(8'h80);
                e.push_back(8'(w));
            end
            M.xfer(e, r);
            if (k == 0) begin
                expect_reply(48'h0210_0040_0010, 6);
                check(wlog[15], 32'h004f_800f);
            end else begin
                expect_reply(24'h029003, 3);
                check(wlog.size(), 0);
            end
        end
    endtask
    task automatic t_errors();
        logic [7:0] fn[4] = '{8'h04, 8'h06, 8'h7f, 8'h03};
        for (int i = 0; i < 4; i++) begin
            go({8'h02, fn[i], 16'h0020, 16'h0000 + 16'(i < 3)}, 6);
            expect_reply({8'h02, fn[i] | 8'h80, (i < 3) ? 8'h01 : 8'h03}, 3);
        end
        mk(24'h028303, 3);
        check(M.crc16(e), 16'h31f1);
        go(48'h0208_1234_0005, 6);
        expect_reply(48'h0208_1234_0005, 6);
    endtask
    task automatic t_silent();
        wlog.delete();
        go(88'h0010_0001_0002_04_1234_0abc, 11);
        expect_reply('0, 0);
        go(72'h0010_0003_0001_02_1234, 9);
        expect_reply('0, 0);
        check(wlog.size(), 2);
        go(48'h0503_0020_0001, 6);
        expect_reply('0, 0);
        M.bad_crc = 1'b1;
        go(48'h0203_0020_0001, 6);
        M.bad_crc = 1'b0;
        expect_reply('0, 0);
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        resetn = 1'b0;
        reg_rdata = '0;
        n_errors = 0;
        total_checks = 0;
        repeat (20) @(negedge clk);
        resetn = 1'b1;
        repeat (2) @(negedge clk);
        t_read();
        t_write();
        t_count();
        t_errors();
        t_silent();
        end_of_test();
    end
    initial begin
        #(25 * 30000);
        n_errors++;
        $display("mismatch at %0t: watchdog expired", $time);
        end_of_test();
    end
endmodule
bind msg_slave msg_slave_checker #(.IDLE_CYC(IDLE_CYC), .MY_ADDR(MY_ADDR)) u_chk (.clk(clk),
    .resetn(resetn), .rx(rx), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
    .reg_req(reg_req));
`default_nettype wire
